/* src/bio_defines.svh */
// Register offsets, field positions and reset values of the bit I/O port
`ifndef BIO_DEFINES_SVH
`define BIO_DEFINES_SVH
`define BIO_OFF_DIRLVL   12'h000
`define BIO_OFF_CMD      12'h004
`define BIO_OFF_AUX      12'h008
`define BIO_OFF_CTRL     12'h00c
`define BIO_OFF_IRQ_STAT 12'h010
`define BIO_OFF_IRQ_MASK 12'h014
`define BIO_DIR_LSB      8
`define BIO_SEL_LSB      8
`define BIO_FLAG_ALLT    0
`define BIO_FLAG_ALLF    1
`define BIO_FLAG_SOMET   2
`define BIO_FLAG_SOMEF   3
`define BIO_AUX_WMASK    16'hc0ff
`define BIO_CTRL_UPPER   0
`define BIO_CTRL_SERIAL  1
`define BIO_IRQ_CMD      0
`define BIO_IRQ_TEST     1
`define BIO_IRQ_W        2
`define BIO_RST_16       16'h0000
`endif

/* src/bio_pkg.sv */
// Types shared by the bit I/O port
package bio_pkg;
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] operand;
  } bio_cmd_t;
  typedef struct packed {
    logic somef;
    logic somet;
    logic allf;
    logic allt;
  } bio_flags_t;
  typedef enum logic [1:0] {BIO_IDLE, BIO_ACCESS} bio_state_t;
endpackage : bio_pkg

/* src/bio_port.sv */
// Eight-pin bit I/O port with APB register access
// Behaviour
// - Upper direction bits make pins outputs
// - Lower bits read live pin levels
// - Select 0, operand 0 drives low
// - Select 0, operand 1 drives high
// - Select 1 holds or toggles output
// - Input with select 0 not tested
// - Input with select 1 tests level
// - Four test flags in aux register
// - Upper group enable routes pins 4-7
// - Serial enable routes lower pins
//
// The address map and the APB register port were chosen for this implementation.
`include "bio_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module bio_port
  import bio_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [7:0]  i_io_pin,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic [7:0]       o_io_pin,
  output logic [7:0]       o_io_pin_oe,
  output logic             o_upper_pin_group_enable,
  output logic             o_second_serial_lower_pins_enable,
  output logic             o_irq
);
  bio_state_t     state_ff;
  logic [7:0]     dir_ff;
  logic [7:0]     out_ff;
  bio_cmd_t       cmd_ff;
  logic [15:0]    aux_ff;
  logic [1:0]     ctrl_ff;
  logic [`BIO_IRQ_W-1:0] stat_ff;
  logic [`BIO_IRQ_W-1:0] mask_ff;
  logic           wr_take;
  logic           acc_start;
  logic           cmd_wr;
  bio_cmd_t       wcmd;
  bio_flags_t     nxt_flags;
  logic [7:0]     nxt_out;
  logic [`BIO_IRQ_W-1:0] ev;
  logic [`BIO_IRQ_W-1:0] clr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // Access taken on the second phase cycle, one wait state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_ff <= BIO_IDLE;
    end else begin
      case (state_ff)
        BIO_IDLE:   state_ff <= (i_psel && i_penable) ? BIO_ACCESS : BIO_IDLE;
        BIO_ACCESS: state_ff <= BIO_IDLE;
        default:    state_ff <= BIO_IDLE;
      endcase
    end
  end

  always_comb begin
    wr_take = (state_ff == BIO_ACCESS) && i_psel && i_penable && i_pwrite;
    acc_start = (state_ff == BIO_IDLE) && i_psel && i_penable;
    cmd_wr  = wr_take && hit(i_paddr, `BIO_OFF_CMD);
    wcmd    = i_pwdata[15:0];
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= acc_start;
    end
  end

  // Command evaluation on the written word
  always_comb begin
    nxt_out   = out_ff;
    nxt_flags = '0;
    for (int n = 0; n < 8; n++) begin
      if (dir_ff[n]) begin
        if (!wcmd.sel[n]) begin
          nxt_out[n] = wcmd.operand[n];
        end else if (wcmd.operand[n]) begin
          nxt_out[n] = ~out_ff[n];
        end
      end
    end
    nxt_flags.allt  = &(~(wcmd.sel & ~dir_ff) | ~(i_io_pin ^ wcmd.operand));
    nxt_flags.allf  = &(~(wcmd.sel & ~dir_ff) | (i_io_pin ^ wcmd.operand));
    nxt_flags.somet = |((wcmd.sel & ~dir_ff) & ~(i_io_pin ^ wcmd.operand));
    nxt_flags.somef = |((wcmd.sel & ~dir_ff) & (i_io_pin ^ wcmd.operand));
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dir_ff <= 8'h00;
    end else if (wr_take && hit(i_paddr, `BIO_OFF_DIRLVL)) begin
      dir_ff <= i_pwdata[15:8];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      out_ff <= 8'h00;
      cmd_ff <= '0;
    end else if (cmd_wr) begin
      out_ff <= nxt_out;
      cmd_ff <= wcmd;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      aux_ff <= `BIO_RST_16;
    end else if (cmd_wr) begin
      aux_ff[3:0] <= nxt_flags;
    end else if (wr_take && hit(i_paddr, `BIO_OFF_AUX)) begin
      aux_ff <= i_pwdata[15:0] & `BIO_AUX_WMASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_ff <= 2'h0;
    end else if (wr_take && hit(i_paddr, `BIO_OFF_CTRL)) begin
      ctrl_ff <= i_pwdata[1:0];
    end
  end

  // Pin drive, gated by routing controls
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_io_pin                          <= 8'h00;
      o_io_pin_oe                       <= 8'h00;
      o_upper_pin_group_enable          <= 1'b0;
      o_second_serial_lower_pins_enable <= 1'b0;
    end else begin
      o_io_pin <= cmd_wr ? nxt_out : out_ff;
      o_io_pin_oe[7:4] <= dir_ff[7:4] & {4{ctrl_ff[`BIO_CTRL_UPPER]}};
      o_io_pin_oe[3:0] <= dir_ff[3:0] & {4{ctrl_ff[`BIO_CTRL_SERIAL]}};
      o_upper_pin_group_enable          <= ctrl_ff[`BIO_CTRL_UPPER];
      o_second_serial_lower_pins_enable <= ctrl_ff[`BIO_CTRL_SERIAL];
    end
  end

  // Sticky events, set wins over clear
  always_comb begin
    ev = '0;
    ev[`BIO_IRQ_CMD]  = cmd_wr;
    ev[`BIO_IRQ_TEST] = cmd_wr && |(wcmd.sel & ~dir_ff);
    clr = (wr_take && hit(i_paddr, `BIO_OFF_IRQ_STAT)) ? i_pwdata[`BIO_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stat_ff <= '0;
      mask_ff <= '0;
      o_irq   <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~clr) | ev;
      if (wr_take && hit(i_paddr, `BIO_OFF_IRQ_MASK)) begin
        mask_ff <= i_pwdata[`BIO_IRQ_W-1:0];
      end
      o_irq <= |(((stat_ff & ~clr) | ev) & mask_ff);
    end
  end

  // Read data and unmapped-address error
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      if (acc_start) begin
        case (i_paddr)
          `BIO_OFF_DIRLVL:   o_prdata <= {16'h0000, dir_ff, i_io_pin};
          `BIO_OFF_CMD:      o_prdata <= {16'h0000, cmd_ff};
          `BIO_OFF_AUX:      o_prdata <= {16'h0000, aux_ff};
          `BIO_OFF_CTRL:     o_prdata <= {30'h0, ctrl_ff};
          `BIO_OFF_IRQ_STAT: o_prdata <= {30'h0, stat_ff};
          `BIO_OFF_IRQ_MASK: o_prdata <= {30'h0, mask_ff};
          default:           o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  set_pin_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && dir_ff[7] && !wcmd.sel[7] && wcmd.operand[7] |=> o_io_pin[7])
    else $error("set command did not drive pin high");
  clr_pin_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && dir_ff[6] && !wcmd.sel[6] && !wcmd.operand[6] |=> !o_io_pin[6])
    else $error("clear command did not drive pin low");
  tog_pin_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && dir_ff[4] && wcmd.sel[4] && wcmd.operand[4] |=> o_io_pin[4] != $past(out_ff[4]))
    else $error("toggle did not invert");
  hold_pin_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && dir_ff[5] && wcmd.sel[5] && !wcmd.operand[5] |=> o_io_pin[5] == $past(out_ff[5]))
    else $error("no-change command altered pin");
  dir_wr_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_take && hit(i_paddr, `BIO_OFF_DIRLVL) |=> dir_ff == $past(i_pwdata[15:8]))
    else $error("direction write lost");
  // nothing tested gives all-true and all-false
  no_test_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && ((wcmd.sel & ~dir_ff) == 8'h00) |=> aux_ff[1:0] == 2'b11 && aux_ff[3:2] == 2'b00)
    else $error("empty test gave wrong flags");
  flag_excl_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr |=> !(aux_ff[`BIO_FLAG_ALLT] && aux_ff[`BIO_FLAG_SOMEF]))
    else $error("all-true with some-false");
  // upper pins not driven when routed away
  upper_off_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    !ctrl_ff[`BIO_CTRL_UPPER] |=> o_io_pin_oe[7:4] == 4'h0)
    else $error("upper pins driven while disabled");
  // lower pins not driven when routed away
  lower_off_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    !ctrl_ff[`BIO_CTRL_SERIAL] |=> o_io_pin_oe[3:0] == 4'h0)
    else $error("lower pins driven while disabled");
  out_dir_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_io_pin_oe & ~$past(dir_ff)) == 8'h00)
    else $error("input pin driven");
  lvl_read_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    acc_start && !i_pwrite && hit(i_paddr, `BIO_OFF_DIRLVL)
    |=> o_prdata[7:0] == $past(i_io_pin))
    else $error("level read mismatch");
  test_hit_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && wcmd.sel[0] && !dir_ff[0] && (wcmd.operand[0] == i_io_pin[0])
    |=> aux_ff[`BIO_FLAG_SOMET] && !aux_ff[`BIO_FLAG_ALLF])
    else $error("matching pin not reported true");
  test_miss_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && wcmd.sel[0] && !dir_ff[0] && (wcmd.operand[0] != i_io_pin[0])
    |=> aux_ff[`BIO_FLAG_SOMEF] && !aux_ff[`BIO_FLAG_ALLT])
    else $error("differing pin not reported false");
  // with pins tested, all and some flags oppose
  flag_pair_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr && ((wcmd.sel & ~dir_ff) != 8'h00)
    |=> (aux_ff[`BIO_FLAG_ALLT] != aux_ff[`BIO_FLAG_SOMEF])
        && (aux_ff[`BIO_FLAG_ALLF] != aux_ff[`BIO_FLAG_SOMET]))
    else $error("test flags inconsistent");

  // Bus phases for the answer check
  sequence apb_setup_s;
    i_psel && !i_penable;
  endsequence
  sequence apb_access_s;
    i_psel && i_penable;
  endsequence
  // Ready answers each access once
  pready_ans_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    apb_setup_s ##1 apb_access_s |=> o_pready)
    else $error("no ready after access phase");
  pready_one_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  // Read bus idles at zero
  rdata_zero_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_pready |-> o_prdata == 32'h0000_0000 && !o_pslverr)
    else $error("read data outside answer");
  // Masked status keeps irq low
  irq_off_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    mask_ff == '0 |=> !o_irq)
    else $error("interrupt raised while masked");
  // Command event latched
  stat_set_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr |=> stat_ff[`BIO_IRQ_CMD])
    else $error("command event not latched");
  // Command word readable back
  cmd_store_a : assert property (@(posedge i_mclk) disable iff (i_rst)
    cmd_wr |=> cmd_ff == $past(wcmd))
    else $error("command word not stored");
endmodule : bio_port
`default_nettype wire

/* testbench/bio_pin_model.sv */
// Far-side pin model: drives input pins, follows enabled outputs
`timescale 1ns/1ns
`default_nettype none
module bio_pin_model (
  input  wire logic [7:0] i_drv,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  output logic      [7:0] o_lvl
);
  assign o_lvl = (i_oe & i_out) | (~i_oe & i_drv);
endmodule : bio_pin_model
`default_nettype wire

/* testbench/test_bio_port.sv */
// Self-checking bench for the bit I/O port
`include "bio_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module test_bio_port
  import bio_pkg::*;
;
  typedef struct packed {
    bio_cmd_t   cmd;
    logic [7:0] drv;
    logic [7:0] lvl;
    logic [3:0] flg;
  } bio_row_t;
  logic        i_mclk, i_rst, psel, penable, pwrite, pready, pslverr, irq, up_en, ser_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  drv, pin_o, pin_oe, lvl;
  int          errors, tests_run;
  bio_row_t    rows [5];
  bio_port u_bio_port (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_io_pin(lvl), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_io_pin(pin_o), .o_io_pin_oe(pin_oe),
    .o_upper_pin_group_enable(up_en), .o_second_serial_lower_pins_enable(ser_en), .o_irq(irq));
  bio_pin_model u_bio_pin_model (.i_drv(drv), .i_out(pin_o), .i_oe(pin_oe), .o_lvl(lvl));
  task automatic results;
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  initial begin
    i_mclk = 1'h0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    rows = '{'{16'h00af, 8'h05, 8'ha5, 4'h3}, '{16'hf0f0, 8'h05, 8'h55, 4'h3},
             '{16'h3f05, 8'h05, 8'h15, 4'h5}, '{16'h0f00, 8'h05, 8'h05, 4'hc},
             '{16'h0303, 8'h00, 8'h00, 4'ha}};
    i_rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    drv = 8'h00;
    errors = 0;
    tests_run = 0;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'h0;
    apb(1'h0, `BIO_OFF_DIRLVL, 32'h0);
    chk(rd, 32'h0);
    chk(32'({ser_en, up_en, pin_oe}), 32'h0);
    apb(1'h1, `BIO_OFF_CTRL, 32'h3);
    apb(1'h1, `BIO_OFF_DIRLVL, 32'hf000);
    repeat (2) @(posedge i_mclk);
    chk(32'(pin_oe), 32'hf0);
    foreach (rows[i]) begin
      drv <= rows[i].drv;
      apb(1'h1, `BIO_OFF_CMD, 32'(rows[i].cmd));
      apb(1'h0, `BIO_OFF_AUX, 32'h0);
      chk(rd, 32'(rows[i].flg));
      apb(1'h0, `BIO_OFF_DIRLVL, 32'h0);
      chk(rd, {16'h0, 8'hf0, rows[i].lvl});
    end
    chk(32'(irq), 32'h0);
    apb(1'h1, `BIO_OFF_IRQ_MASK, 32'h1);
    apb(1'h0, `BIO_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    chk(32'(irq), 32'h1);
    apb(1'h1, `BIO_OFF_IRQ_STAT, 32'h3);
    apb(1'h0, `BIO_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'h1, `BIO_OFF_CTRL, 32'h2);
    apb(1'h0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    chk(32'({up_en, ser_en, pin_oe}), 32'h100);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'h0;
    apb(1'h0, `BIO_OFF_DIRLVL, 32'h0);
    chk(rd, 32'h0);
    chk(32'({irq, up_en, ser_en, pin_oe}), 32'h0);
    results();
  end
endmodule : test_bio_port
`default_nettype wire
